// >>> rtl/pm_defs.svh
`ifndef PM_DEFS_SVH
`define PM_DEFS_SVH

// --------------------------------------------------------------
// Register offsets within the block
// --------------------------------------------------------------
`define PM_OFS_EN_HIGH 4'h3
`define PM_OFS_CTL_LOW 4'h4
`define PM_OFS_CTL_HIGH 4'h5
`define PM_OFS_TMR0 4'h8
`define PM_OFS_TMR1 4'h9
`define PM_OFS_TMR2 4'ha

// --------------------------------------------------------------
// Field positions, masks and reset values
// --------------------------------------------------------------
`define PM_BTN_GATE_BIT 0
`define PM_RTC_GATE_BIT 2
`define PM_MASTER_GATE_BIT 0
`define PM_BM_WAKE_BIT 1
`define PM_GLOBAL_REL_BIT 2
`define PM_OVR_EN_BIT 1
`define PM_TMR_MSB_BIT 23
`define PM_EN_HIGH_MASK 8'h05
`define PM_CTL_LOW_MASK 8'h03
`define PM_GLOBAL_REL_MASK 8'h04
`define PM_CTL_HIGH_MASK 8'h02
`define PM_REG_RESET 8'h00
`define PM_TMR_W 24
`define PM_TMR_RESET 24'h000000

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define PM_CLK_HZ 40000000
`define PM_TMR_HZ 3579545
`define PM_ACC_W 26
`define PM_OVR_HOLD_S 4
`define PM_HOLD_W 28

`endif

// >>> rtl/pm_fixed_event_ctl.sv
`timescale 1ns/10ps
`default_nettype none
`include "pm_defs.svh"

module pm_fixed_event_ctl #(
    parameter int unsigned OVR_HOLD_CYCLES = `PM_OVR_HOLD_S * `PM_CLK_HZ
) (
    // Clock and standby power-on reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Host I/O register port, offsets from the block base
    input wire logic [3:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Asynchronous pins
    input wire logic host_bus_reset,
    input wire logic button_in,
    input wire logic rtc_alarm2,
    input wire logic busmaster_request,
    input wire logic clk14_present,
    // Chip-side controls
    input wire logic busmaster_control_bit,
    input wire logic timer_event_gate,
    input wire logic firmware_event_gate,
    input wire logic sleep_request,
    input wire logic button_flag_clr,
    input wire logic alarm_flag_clr,
    input wire logic override_flag_clr,
    input wire logic timer_flag_clr,
    input wire logic firmware_flag_clr,
    // Flags
    output logic button_press_flag,
    output logic clock_alarm_flag,
    output logic button_override_flag,
    output logic timer_msb_toggle_flag,
    output logic firmware_event_flag,
    // Events and power pin
    output logic sci,
    output logic smi,
    output logic wake_event,
    output logic power_on_output_n,
    output logic power_on_oe
);
    localparam logic [`PM_HOLD_W-1:0] HOLD_LIM = `PM_HOLD_W'(OVR_HOLD_CYCLES);

    // --------------------------------------------------------------
    // Pin synchronisers and edge detect
    // --------------------------------------------------------------
    logic s_host_rst, s_button, s_alarm, s_bm_req, s_clk14;
    logic btn_prev_ff, alarm_prev_ff;
    logic btn_rise, alarm_rise;

    pm_sync2 #(.W(5)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d({host_bus_reset, button_in, rtc_alarm2, busmaster_request, clk14_present}),
        .q({s_host_rst, s_button, s_alarm, s_bm_req, s_clk14})
    );

    assign btn_rise = s_button && !btn_prev_ff;
    assign alarm_rise = s_alarm && !alarm_prev_ff;

    // --------------------------------------------------------------
    // Timer
    // --------------------------------------------------------------
    pm_timer_if tif ();
    pm_timer u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tif(tif)
    );

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    pm_pkg::power_state_t state_ff, nxt_state;
    logic [7:0] en_high_ff, nxt_en_high;
    logic [7:0] ctl_low_ff, nxt_ctl_low;
    logic [7:0] ctl_high_ff, nxt_ctl_high;
    logic gbl_ff, nxt_gbl;
    logic btn_flag_ff, nxt_btn_flag;
    logic alarm_flag_ff, nxt_alarm_flag;
    logic ovr_flag_ff, nxt_ovr_flag;
    logic tmr_flag_ff, nxt_tmr_flag;
    logic fw_flag_ff, nxt_fw_flag;
    logic [15:0] latch_ff, nxt_latch;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [`PM_HOLD_W-1:0] hold_ff, nxt_hold;
    logic sci_ff, nxt_sci;
    logic smi_ff, nxt_smi;
    logic wake_ff, nxt_wake;
    logic pon_n_ff, nxt_pon_n;
    logic pon_oe_ff, nxt_pon_oe;
    logic ovr_fire, gbl_write, btn_pending, working, master;

    assign working = state_ff == pm_pkg::ST_WORKING;
    assign master = ctl_low_ff[`PM_MASTER_GATE_BIT];
    assign btn_pending = btn_flag_ff && en_high_ff[`PM_BTN_GATE_BIT];
    assign gbl_write = io_wr && io_addr == `PM_OFS_CTL_LOW && io_wdata[`PM_GLOBAL_REL_BIT];
    // Fires once per hold; the counter parks at the limit until release
    assign ovr_fire = s_button && ctl_high_ff[`PM_OVR_EN_BIT]
        && hold_ff == HOLD_LIM - `PM_HOLD_W'(1) && state_ff != pm_pkg::ST_SOFT_OFF;

    assign tif.run = working && s_clk14;
    assign tif.clear = s_host_rst;

    always_comb begin
        nxt_en_high = en_high_ff;
        nxt_ctl_low = ctl_low_ff;
        nxt_ctl_high = ctl_high_ff;
        nxt_latch = latch_ff;
        nxt_rdata = rdata_ff;
        // Register writes; reserved bits are masked off
        if (io_wr) begin
            unique case (io_addr)
                `PM_OFS_EN_HIGH: nxt_en_high = io_wdata & `PM_EN_HIGH_MASK;
                `PM_OFS_CTL_LOW: nxt_ctl_low = io_wdata & `PM_CTL_LOW_MASK;
                `PM_OFS_CTL_HIGH: nxt_ctl_high = io_wdata & `PM_CTL_HIGH_MASK;
                default: ;
            endcase
        end
        // Register reads; a read of the low timer byte freezes the upper two
        if (io_rd) begin
            unique case (io_addr)
                `PM_OFS_EN_HIGH: nxt_rdata = en_high_ff;
                `PM_OFS_CTL_LOW: nxt_rdata = ctl_low_ff | (gbl_ff ? `PM_GLOBAL_REL_MASK : 8'h00);
                `PM_OFS_CTL_HIGH: nxt_rdata = ctl_high_ff;
                `PM_OFS_TMR0: begin
                    nxt_rdata = tif.count[7:0];
                    nxt_latch = tif.count[23:8];
                end
                `PM_OFS_TMR1: nxt_rdata = latch_ff[7:0];
                `PM_OFS_TMR2: nxt_rdata = latch_ff[15:8];
                default: nxt_rdata = 8'h00;
            endcase
        end
        if (s_host_rst) begin
            nxt_latch = '0;
        end
    end

    always_comb begin
        // Flags: clear first, so a same-cycle set wins
        nxt_btn_flag = btn_flag_ff;
        if (button_flag_clr) nxt_btn_flag = 1'b0;
        if (btn_rise) nxt_btn_flag = 1'b1;
        if (ovr_fire) nxt_btn_flag = 1'b0;
        nxt_ovr_flag = ovr_flag_ff;
        if (override_flag_clr) nxt_ovr_flag = 1'b0;
        if (ovr_fire) nxt_ovr_flag = 1'b1;
        nxt_alarm_flag = alarm_flag_ff;
        if (alarm_flag_clr) nxt_alarm_flag = 1'b0;
        if (alarm_rise) nxt_alarm_flag = 1'b1;
        nxt_tmr_flag = tmr_flag_ff;
        if (timer_flag_clr) nxt_tmr_flag = 1'b0;
        if (tif.msb_toggle) nxt_tmr_flag = 1'b1;
        nxt_fw_flag = fw_flag_ff;
        nxt_gbl = gbl_ff;
        if (firmware_flag_clr) begin
            nxt_fw_flag = 1'b0;
            nxt_gbl = 1'b0;
        end
        if (gbl_write) begin
            nxt_fw_flag = 1'b1;
            nxt_gbl = 1'b1;
        end
        // Hold counter for the override
        nxt_hold = '0;
        if (s_button) begin
            nxt_hold = (hold_ff == HOLD_LIM) ? hold_ff : hold_ff + `PM_HOLD_W'(1);
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_wake = 1'b0;
        unique case (state_ff)
            pm_pkg::ST_WORKING: begin
                if (ovr_fire) nxt_state = pm_pkg::ST_SOFT_OFF;
                else if (sleep_request) nxt_state = pm_pkg::ST_SLEEPING;
            end
            pm_pkg::ST_SLEEPING: begin
                if (ovr_fire) begin
                    nxt_state = pm_pkg::ST_SOFT_OFF;
                end else if (btn_pending) begin
                    nxt_wake = 1'b1;
                    nxt_state = pm_pkg::ST_WORKING;
                end
            end
            pm_pkg::ST_SOFT_OFF: begin
                // The button always powers the machine up, gated or not
                if ((s_bm_req && ctl_low_ff[`PM_BM_WAKE_BIT]) || btn_rise) begin
                    nxt_state = pm_pkg::ST_WORKING;
                end
            end
            default: nxt_state = pm_pkg::ST_WORKING;
        endcase
        // Open-drain power pin: driven low while on, released in soft-off
        nxt_pon_n = nxt_state == pm_pkg::ST_SOFT_OFF;
        nxt_pon_oe = nxt_state != pm_pkg::ST_SOFT_OFF;
        nxt_sci = master && (
            (btn_pending && working)
            || (alarm_flag_ff && en_high_ff[`PM_RTC_GATE_BIT])
            || (ctl_low_ff[`PM_BM_WAKE_BIT] && busmaster_control_bit)
            || (tmr_flag_ff && timer_event_gate));
        nxt_smi = fw_flag_ff && firmware_event_gate;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= pm_pkg::ST_WORKING;
            en_high_ff <= `PM_REG_RESET;
            ctl_low_ff <= `PM_REG_RESET;
            ctl_high_ff <= `PM_REG_RESET;
            gbl_ff <= 1'b0;
            btn_flag_ff <= 1'b0;
            alarm_flag_ff <= 1'b0;
            ovr_flag_ff <= 1'b0;
            tmr_flag_ff <= 1'b0;
            fw_flag_ff <= 1'b0;
            latch_ff <= '0;
            rdata_ff <= 8'h00;
            hold_ff <= '0;
            btn_prev_ff <= 1'b0;
            alarm_prev_ff <= 1'b0;
            sci_ff <= 1'b0;
            smi_ff <= 1'b0;
            wake_ff <= 1'b0;
            pon_n_ff <= 1'b0;
            pon_oe_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            en_high_ff <= nxt_en_high;
            ctl_low_ff <= nxt_ctl_low;
            ctl_high_ff <= nxt_ctl_high;
            gbl_ff <= nxt_gbl;
            btn_flag_ff <= nxt_btn_flag;
            alarm_flag_ff <= nxt_alarm_flag;
            ovr_flag_ff <= nxt_ovr_flag;
            tmr_flag_ff <= nxt_tmr_flag;
            fw_flag_ff <= nxt_fw_flag;
            latch_ff <= nxt_latch;
            rdata_ff <= nxt_rdata;
            hold_ff <= nxt_hold;
            btn_prev_ff <= s_button;
            alarm_prev_ff <= s_alarm;
            sci_ff <= nxt_sci;
            smi_ff <= nxt_smi;
            wake_ff <= nxt_wake;
            pon_n_ff <= nxt_pon_n;
            pon_oe_ff <= nxt_pon_oe;
        end
    end

    assign io_rdata = rdata_ff;
    assign button_press_flag = btn_flag_ff;
    assign clock_alarm_flag = alarm_flag_ff;
    assign button_override_flag = ovr_flag_ff;
    assign timer_msb_toggle_flag = tmr_flag_ff;
    assign firmware_event_flag = fw_flag_ff;
    assign sci = sci_ff;
    assign smi = smi_ff;
    assign wake_event = wake_ff;
    assign power_on_output_n = pon_n_ff;
    assign power_on_oe = pon_oe_ff;

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_BTN_SET: assert property (btn_rise && !ovr_fire |=> btn_flag_ff)
        else $error("button flag not set on press");

    AST_BTN_CLR: assert property (button_flag_clr && !btn_rise |=> !btn_flag_ff)
        else $error("button flag not cleared");

    AST_WAKE: assert property (state_ff == pm_pkg::ST_SLEEPING && btn_pending
        && !ovr_fire |=> wake_ff && working) else $error("sleep wake missing");

    AST_ALARM_SET: assert property (alarm_rise |=> alarm_flag_ff)
        else $error("alarm flag not set");

    AST_ALARM_SCI: assert property (master && alarm_flag_ff && en_high_ff[`PM_RTC_GATE_BIT]
        |=> sci_ff) else $error("alarm did not raise sci");

    AST_RSVD_EN: assert property (io_rd && io_addr == `PM_OFS_EN_HIGH
        |=> (rdata_ff & ~`PM_EN_HIGH_MASK) == 8'h00) else $error("reserved bits not zero");

    AST_MASTER_GATE: assert property (!master |=> !sci_ff)
        else $error("sci raised with master gate clear");

    AST_BM_SCI: assert property (master && ctl_low_ff[`PM_BM_WAKE_BIT]
        && busmaster_control_bit |=> sci_ff) else $error("bus-master sci missing");

    AST_GBL_SET: assert property (gbl_write |=> fw_flag_ff && gbl_ff ##1
        (smi_ff == $past(firmware_event_gate))) else $error("global release not seen");

    AST_SMI_GATE: assert property (!firmware_event_gate |=> !smi_ff)
        else $error("smi raised with gate clear");

    AST_GBL_HOLD: assert property (gbl_ff && !firmware_flag_clr |=> gbl_ff)
        else $error("global release dropped without clear");

    AST_GBL_CLR: assert property (firmware_flag_clr && !gbl_write
        |=> !gbl_ff && !fw_flag_ff) else $error("global release not cleared");

    AST_OVR: assert property (ovr_fire |=> !btn_flag_ff && ovr_flag_ff
        && state_ff == pm_pkg::ST_SOFT_OFF ##1 !power_on_oe) else $error("override failed");

    AST_LATCH: assert property (io_rd && io_addr == `PM_OFS_TMR0 && !s_host_rst
        |=> latch_ff == $past(tif.count[23:8]) && rdata_ff == $past(tif.count[7:0]))
        else $error("timer latch incoherent");

    AST_RSVD: assert property (io_rd && io_addr == `PM_OFS_CTL_HIGH
        |=> (rdata_ff & ~`PM_CTL_HIGH_MASK) == 8'h00) else $error("reserved bits not zero");

    AST_TMR_FLAG: assert property (tif.msb_toggle |=> tmr_flag_ff)
        else $error("timer flag not set on msb change");

    AST_TMR_HOLD: assert property (!tif.run && !tif.clear |=> $stable(tif.count))
        else $error("timer moved while stopped");

    AST_TMR_CLR: assert property (tif.clear |=> tif.count == `PM_TMR_RESET)
        else $error("timer not cleared");

    AST_RO_WRITE: assert property (io_wr && io_addr >= `PM_OFS_TMR0
        |=> $stable(en_high_ff) && $stable(ctl_low_ff) && $stable(ctl_high_ff))
        else $error("read-only write took effect");

    AST_BM_WAKE: assert property (state_ff == pm_pkg::ST_SOFT_OFF && s_bm_req
        && ctl_low_ff[`PM_BM_WAKE_BIT] |=> working && !power_on_output_n)
        else $error("bus-master wake failed");

    AST_OFF_HOLD: assert property (state_ff == pm_pkg::ST_SOFT_OFF
        && !ctl_low_ff[`PM_BM_WAKE_BIT] && !btn_rise |=> power_on_output_n)
        else $error("soft-off left without cause");

    AST_PON_OE: assert property (power_on_oe != power_on_output_n)
        else $error("power pin driven while released");

    COV_OVERRIDE: cover property (ovr_fire ##1 state_ff == pm_pkg::ST_SOFT_OFF);
    COV_WAKE: cover property (state_ff == pm_pkg::ST_SLEEPING ##1 wake_ff);
    COV_TMR_READ: cover property (io_rd && io_addr == `PM_OFS_TMR0 ##[1:4] io_rd
        && io_addr == `PM_OFS_TMR1);
    COV_BM_WAKE: cover property (state_ff == pm_pkg::ST_SOFT_OFF ##1 working);
    COV_SCI_DROP: cover property (sci_ff && !master ##1 !sci_ff);
endmodule : pm_fixed_event_ctl

`default_nettype wire

// >>> rtl/pm_pkg.sv
package pm_pkg;

    typedef enum logic [2:0] {
        ST_WORKING = 3'b001,
        ST_SLEEPING = 3'b010,
        ST_SOFT_OFF = 3'b100
    } power_state_t;

endpackage : pm_pkg

// >>> rtl/pm_sync2.sv
`timescale 1ns/10ps
`default_nettype none

module pm_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule : pm_sync2

`default_nettype wire

// >>> rtl/pm_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "pm_defs.svh"

module pm_timer (
    // Clock and standby reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control and count
    pm_timer_if.tmr tif
);
    logic [`PM_ACC_W-1:0] acc_ff, nxt_acc;
    logic [`PM_TMR_W-1:0] count_ff, nxt_count;
    logic toggle_ff, nxt_toggle;
    logic [`PM_ACC_W-1:0] sum;

    // --------------------------------------------------------------
    // Fractional tick: exact 3.579545 MHz average from the 40 MHz clock
    // --------------------------------------------------------------
    always_comb begin
        sum = acc_ff + `PM_ACC_W'(`PM_TMR_HZ);
        nxt_acc = acc_ff;
        nxt_count = count_ff;
        if (tif.run) begin
            if (sum >= `PM_ACC_W'(`PM_CLK_HZ)) begin
                nxt_acc = sum - `PM_ACC_W'(`PM_CLK_HZ);
                nxt_count = count_ff + `PM_TMR_W'(1);
            end else begin
                nxt_acc = sum;
            end
        end
        nxt_toggle = nxt_count[`PM_TMR_MSB_BIT] != count_ff[`PM_TMR_MSB_BIT];
        if (tif.clear) begin
            nxt_acc = '0;
            nxt_count = `PM_TMR_RESET;
            nxt_toggle = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= '0;
            count_ff <= `PM_TMR_RESET;
            toggle_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            count_ff <= nxt_count;
            toggle_ff <= nxt_toggle;
        end
    end

    assign tif.count = count_ff;
    assign tif.msb_toggle = toggle_ff;
endmodule : pm_timer

`default_nettype wire

// >>> rtl/pm_timer_if.sv
`timescale 1ns/10ps
`default_nettype none

interface pm_timer_if;
    logic run;
    logic clear;
    logic [23:0] count;
    logic msb_toggle;

    modport ctl (output run, output clear, input count, input msb_toggle);
    modport tmr (input run, input clear, output count, output msb_toggle);
endinterface : pm_timer_if

`default_nettype wire

// >>> tb/acpi_pm1_event_control_timer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module acpi_pm1_event_control_timer_tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic host_bus_reset = 1'b0, button_in = 1'b0, rtc_alarm2 = 1'b0;
    logic busmaster_request = 1'b0, clk14_present = 1'b1, busmaster_control_bit = 1'b0;
    logic sleep_request = 1'b0, button_flag_clr = 1'b0, alarm_flag_clr = 1'b0;
    logic override_flag_clr = 1'b0, firmware_flag_clr = 1'b0, firmware_event_gate = 1'b1;
    logic [3:0] io_addr, a;
    logic io_rd, io_wr;
    logic [7:0] io_wdata, io_rdata, sh_en, sh_c0, sh_c1;
    logic sh_gbl, wake_seen = 1'b0;
    logic button_press_flag, clock_alarm_flag, button_override_flag, timer_msb_toggle_flag;
    logic firmware_event_flag, sci, smi, wake_event, power_on_output_n, power_on_oe;
    logic [23:0] c1, c2;
    logic [31:0] lfsr = 32'h0a46;
    logic [3:0] wa [5] = '{4'h3, 4'h4, 4'h5, 4'h8, 4'hb};
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    always #12.5 sys_clk = ~sys_clk;

    pm_host_model host (.sys_clk(sys_clk), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
        .io_wdata(io_wdata), .io_rdata(io_rdata));

    pm_fixed_event_ctl #(.OVR_HOLD_CYCLES(16)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
        .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .host_bus_reset(host_bus_reset), .button_in(button_in),
        .rtc_alarm2(rtc_alarm2), .busmaster_request(busmaster_request),
        .clk14_present(clk14_present), .busmaster_control_bit(busmaster_control_bit),
        .timer_event_gate(1'b0), .firmware_event_gate(firmware_event_gate),
        .sleep_request(sleep_request),
        .button_flag_clr(button_flag_clr), .alarm_flag_clr(alarm_flag_clr),
        .override_flag_clr(override_flag_clr), .timer_flag_clr(1'b0),
        .firmware_flag_clr(firmware_flag_clr), .button_press_flag(button_press_flag),
        .clock_alarm_flag(clock_alarm_flag), .button_override_flag(button_override_flag),
        .timer_msb_toggle_flag(timer_msb_toggle_flag),
        .firmware_event_flag(firmware_event_flag), .sci(sci), .smi(smi),
        .wake_event(wake_event), .power_on_output_n(power_on_output_n),
        .power_on_oe(power_on_oe));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic summarize();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic chkb(input string nm, input logic exp, input logic got);
        chk(nm, {23'h0, exp}, {23'h0, got});
    endtask : chkb

    task automatic rdchk(input logic [3:0] ad, input logic [7:0] exp);
        logic [7:0] v;
        host.rd(ad, v);
        chk($sformatf("reg %h", ad), {16'h0, exp}, {16'h0, v});
    endtask : rdchk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    // A run that stalls is cut off and counted as a mismatch
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (wake_event === 1'b1) wake_seen <= 1'b1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            summarize();
        end
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        cyc(2);
        chkb("power oe", 1'b1, power_on_oe);
        for (int i = 0; i < 5; i++) rdchk(wa[i], 8'h00);
        sh_en = 8'h00;
        sh_c0 = 8'h00;
        sh_c1 = 8'h00;
        sh_gbl = 1'b0;
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            a = wa[lfsr[10:8] % 5];
            host.wr(a, lfsr[7:0]);
            case (a)
                4'h3: sh_en = lfsr[7:0] & 8'h05;
                4'h4: begin
                    sh_c0 = lfsr[7:0] & 8'h03;
                    sh_gbl = sh_gbl | lfsr[2];
                end
                4'h5: sh_c1 = lfsr[7:0] & 8'h02;
                default: ;
            endcase
            rdchk(4'h3, sh_en);
            rdchk(4'h4, sh_c0 | {5'h0, sh_gbl, 2'h0});
            rdchk(4'h5, sh_c1);
            chkb("firmware flag", sh_gbl, firmware_event_flag);
            chkb("smi", sh_gbl, smi);
        end
        host.wr(4'h4, 8'h04);
        host.wr(4'h4, 8'h00);
        rdchk(4'h4, 8'h04);
        chkb("smi", 1'b1, smi);
        @(posedge sys_clk) firmware_flag_clr <= 1'b1;
        @(posedge sys_clk) firmware_flag_clr <= 1'b0;
        cyc(2);
        rdchk(4'h4, 8'h00);
        chkb("firmware flag", 1'b0, firmware_event_flag);
        chkb("smi", 1'b0, smi);
        @(posedge sys_clk) firmware_event_gate <= 1'b0;
        host.wr(4'h4, 8'h04);
        cyc(2);
        chkb("firmware flag", 1'b1, firmware_event_flag);
        chkb("smi", 1'b0, smi);
        @(posedge sys_clk) firmware_flag_clr <= 1'b1;
        @(posedge sys_clk) firmware_flag_clr <= 1'b0;
        firmware_event_gate <= 1'b1;
        host.wr(4'h3, 8'h00);
        host.wr(4'h5, 8'h00);
        host.rd_count(c1);
        cyc(1000);
        host.rd_count(c2);
        chkb("timer rate", 1'b1, (c2 - c1 >= 24'd88) && (c2 - c1 <= 24'd92));
        @(posedge sys_clk) clk14_present <= 1'b0;
        cyc(4);
        host.rd_count(c1);
        cyc(500);
        host.rd_count(c2);
        chk("timer held", c1, c2);
        @(posedge sys_clk) clk14_present <= 1'b1;
        host_bus_reset <= 1'b1;
        cyc(4);
        host.rd_count(c1);
        chk("timer bus reset", 24'h000000, c1);
        @(posedge sys_clk) host_bus_reset <= 1'b0;
        host.wr(4'h4, 8'h01);
        @(posedge sys_clk) button_in <= 1'b1;
        cyc(6);
        chkb("button flag", 1'b1, button_press_flag);
        chkb("sci", 1'b0, sci);
        @(posedge sys_clk) button_in <= 1'b0;
        host.wr(4'h3, 8'h01);
        cyc(2);
        chkb("sci", 1'b1, sci);
        host.wr(4'h4, 8'h00);
        cyc(2);
        chkb("sci", 1'b0, sci);
        @(posedge sys_clk) button_flag_clr <= 1'b1;
        @(posedge sys_clk) button_flag_clr <= 1'b0;
        host.wr(4'h3, 8'h00);
        host.wr(4'h4, 8'h01);
        chkb("button flag", 1'b0, button_press_flag);
        @(posedge sys_clk) rtc_alarm2 <= 1'b1;
        cyc(4);
        @(posedge sys_clk) rtc_alarm2 <= 1'b0;
        cyc(3);
        chkb("alarm flag", 1'b1, clock_alarm_flag);
        chkb("sci", 1'b0, sci);
        host.wr(4'h3, 8'h04);
        cyc(2);
        chkb("sci", 1'b1, sci);
        @(posedge sys_clk) alarm_flag_clr <= 1'b1;
        @(posedge sys_clk) alarm_flag_clr <= 1'b0;
        cyc(2);
        chkb("alarm flag", 1'b0, clock_alarm_flag);
        chkb("sci", 1'b0, sci);
        host.wr(4'h3, 8'h00);
        host.wr(4'h5, 8'h02);
        host.wr(4'h4, 8'h00);
        @(posedge sys_clk) button_in <= 1'b1;
        cyc(30);
        chkb("override flag", 1'b1, button_override_flag);
        chkb("button flag", 1'b0, button_press_flag);
        chkb("power oe", 1'b0, power_on_oe);
        chkb("power pin", 1'b1, power_on_output_n);
        @(posedge sys_clk) button_in <= 1'b0;
        override_flag_clr <= 1'b1;
        @(posedge sys_clk) override_flag_clr <= 1'b0;
        busmaster_request <= 1'b1;
        cyc(8);
        chkb("override flag", 1'b0, button_override_flag);
        chkb("power oe", 1'b0, power_on_oe);
        host.wr(4'h4, 8'h03);
        cyc(6);
        chkb("power pin", 1'b0, power_on_output_n);
        chkb("power oe", 1'b1, power_on_oe);
        chkb("sci", 1'b0, sci);
        @(posedge sys_clk) busmaster_control_bit <= 1'b1;
        busmaster_request <= 1'b0;
        cyc(3);
        chkb("sci", 1'b1, sci);
        @(posedge sys_clk) busmaster_control_bit <= 1'b0;
        host.wr(4'h4, 8'h00);
        host.wr(4'h5, 8'h00);
        host.wr(4'h3, 8'h01);
        @(posedge sys_clk) sleep_request <= 1'b1;
        @(posedge sys_clk) sleep_request <= 1'b0;
        cyc(2);
        chkb("wake", 1'b0, wake_seen);
        @(posedge sys_clk) button_in <= 1'b1;
        cyc(6);
        @(posedge sys_clk) button_in <= 1'b0;
        cyc(4);
        chkb("wake", 1'b1, wake_seen);
        summarize();
    end
endmodule : acpi_pm1_event_control_timer_tb_top

`default_nettype wire

// >>> tb/pm_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module pm_host_model (
    // Clock
    input wire logic sys_clk,
    // Register port
    output var logic [3:0] io_addr,
    output var logic io_rd,
    output var logic io_wr,
    output var logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    initial begin
        io_addr = 4'h0;
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_wdata = 8'h00;
    end

    // Data is inverted after a write so a stale value never passes for a good one
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge sys_clk);
        io_wr <= 1'b0;
        io_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        @(posedge sys_clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge sys_clk);
        io_rd <= 1'b0;
        #1;
        q = io_rdata;
    endtask : rd

    // Low byte first, so the upper bytes come from the latch it loads
    task automatic rd_count(output logic [23:0] c);
        rd(4'h8, c[7:0]);
        rd(4'h9, c[15:8]);
        rd(4'ha, c[23:16]);
    endtask : rd_count
endmodule : pm_host_model

`default_nettype wire
